// [logic/e1f_bit_delay.v]
// Purpose: Fixed delay of a serial bit stream in line-clock steps.
// Assumes: adv pulses once per line-clock period.
// Notes: The delay is exactly DEPTH advances.
`timescale 1ns/1ps
`default_nettype none

module e1f_bit_delay #(
  parameter DEPTH = 2
) (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Stream.
  input wire adv,
  input wire din,
  output wire dout
);

  reg [DEPTH-1:0] stage_r;

  // Each stage moves one place per line-clock step.
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_stage
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_r[i] <= 1'b0;
        end else if (adv) begin
          if (i == 0) begin
            stage_r[i] <= din;
          end else begin
            stage_r[i] <= stage_r[i-1];
          end
        end
      end
    end
  endgenerate

  assign dout = stage_r[DEPTH-1];

endmodule // e1f_bit_delay

`default_nettype wire

// [logic/e1f_framer.v]
// Purpose: E1 framer transmit timing, idle insertion and receive signaling.
// Assumes: Line clocks are far slower than clk and sampled by it.
// Notes: Transmit line code is AMI; receive accepts HDB3 or AMI.
// Functional notes
// - In CAS, frame 0 slot 16 carries alignment pattern, extra bits, alarm.
// - CAS with internal source takes extra bits from register bits 0,1,3.
// - CAS with external source samples extra_bit_in at extra-bit positions.
// - CCS mode passes every slot 16 bit from tx_serial_in.
// - Four 8-bit idle masks, slot 0 at bit 0, slot 31 last.
// - A set mask bit replaces that slot with the idle byte.
// - Mask bits for slots 0 and 16 are ignored.
// - Multiframe sync rise sets multiframe alignment, shown on align output.
// - Frame sync rise sets frame position, shown on align frame output.
// - With sync inputs low the transmit side free-runs and still reports.
// - Align frame output marks even or odd frames per parity select.
// - Multiframe output follows sync rise; frame output on boundaries.
// - Transmit latency is five line-clock periods.
// - Receive passes slot 16 unchanged and extracts it serially.
// - Signaling valid in slot k-1 and k+16 of frame k.
// - Signaling bits A to D sit in bit positions 5 to 8.
// - No valid signaling during slots 0 and 16.
// - Receive data reaches rx_serial_out six periods later, decoded only.
// - CAS multiframe may start on any frame; CRC4 on an align frame.
// - Receive syncs rise one period early; multiframe syncs fall with it.
// - Frame 0 slot 16 bit 6 carries the distant multiframe alarm.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "e1f_regs.vh"

module e1f_framer (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // APB register port.
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Transmit system and line side.
  input wire tx_line_clock,
  input wire tx_serial_in,
  input wire extra_bit_in,
  input wire tx_frame_sync_in,
  input wire tx_multiframe_sync_in,
  output reg line_out_pos,
  output reg line_out_neg,
  output reg tx_multiframe_align_out,
  output reg tx_align_frame_out,
  // Receive line and system side.
  input wire rx_line_clock,
  input wire line_in_pos,
  input wire line_in_neg,
  output reg rx_serial_out,
  output reg rx_signaling_out,
  output reg rx_frame_sync_out,
  output reg rx_multiframe_sync_out,
  output reg rx_crc_multiframe_sync_out,
  output reg rx_align_frame_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Timeslot number of a bit position within the frame.
  function [4:0] slot_of;
    input [7:0] pos;
    begin
      slot_of = pos[7:3];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisation and line-clock edges
  // ----------------------------------------------------------------------
  wire [8:0] pin_s;
  reg tx_clk_d_r;
  reg rx_clk_d_r;
  wire tx_adv;
  wire rx_adv;

  e1f_sync2 #(
    .WIDTH(9)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({tx_line_clock, tx_serial_in, extra_bit_in, tx_frame_sync_in,
          tx_multiframe_sync_in, rx_line_clock, line_in_pos, line_in_neg,
          1'b0}),
    .dout(pin_s)
  );

  wire tx_clk_s = pin_s[8];
  wire ti_ser = pin_s[7];
  wire ti_xb = pin_s[6];
  wire ti_fs = pin_s[5];
  wire ti_ms = pin_s[4];
  wire rx_clk_s = pin_s[3];
  wire ri_pos = pin_s[2];
  wire ri_neg = pin_s[1];

  // Previous level of each line clock, for rising-edge detection.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_clk_d_r <= 1'b0;
      rx_clk_d_r <= 1'b0;
    end else begin
      tx_clk_d_r <= tx_clk_s;
      rx_clk_d_r <= rx_clk_s;
    end
  end

  assign tx_adv = tx_clk_s & ~tx_clk_d_r;
  assign rx_adv = rx_clk_s & ~rx_clk_d_r;

  // ----------------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------------
  reg [7:0] ctrl_r;
  reg [7:0] xbits_r;
  reg [31:0] idle_r;
  reg [3:0] tx_fr_r;
  reg [3:0] rx_fr_r;
  reg rx_lock_r;
  reg [31:0] rd_nxt;
  reg hit_nxt;
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite & ~pslverr;

  // Read mux and address decode; reserved bits read as zero.
  always @* begin
    rd_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (paddr)
      `E1F_OFS_CTRL: rd_nxt = {24'h00_0000, ctrl_r};
      `E1F_OFS_XBITS: rd_nxt = {28'h000_0000, xbits_r[3:0]};
      `E1F_OFS_IDLE0: rd_nxt = {24'h00_0000, idle_r[7:0]};
      `E1F_OFS_IDLE1: rd_nxt = {24'h00_0000, idle_r[15:8]};
      `E1F_OFS_IDLE2: rd_nxt = {24'h00_0000, idle_r[23:16]};
      `E1F_OFS_IDLE3: rd_nxt = {24'h00_0000, idle_r[31:24]};
      `E1F_OFS_STATUS: rd_nxt = {23'h00_0000, rx_lock_r, rx_fr_r, tx_fr_r};
      default: hit_nxt = 1'b0;
    endcase
  end

  // Zero-wait slave: answer is ready in the access phase.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~hit_nxt;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      end
    end
  end

  // Register writes; reserved extra-bit positions are expected zero.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `E1F_CTRL_RST;
      xbits_r <= `E1F_XBITS_RST;
      idle_r <= {4{`E1F_IDLE_RST}};
    end else if (apb_wr) begin
      case (paddr)
        `E1F_OFS_CTRL: ctrl_r <= pwdata[7:0];
        `E1F_OFS_XBITS: xbits_r <= pwdata[7:0];
        `E1F_OFS_IDLE0: idle_r[7:0] <= pwdata[7:0];
        `E1F_OFS_IDLE1: idle_r[15:8] <= pwdata[7:0];
        `E1F_OFS_IDLE2: idle_r[23:16] <= pwdata[7:0];
        `E1F_OFS_IDLE3: idle_r[31:24] <= pwdata[7:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  wire hdb3_en = ctrl_r[`E1F_CTRL_HDB3];
  wire xsrc_int = ctrl_r[`E1F_CTRL_XSRC];
  wire ccs_mode = ctrl_r[`E1F_CTRL_CCS];
  wire odd_align = ctrl_r[`E1F_CTRL_PARITY];

  // ----------------------------------------------------------------------
  // Transmit timing and slot insertion
  // ----------------------------------------------------------------------
  reg [7:0] tx_pos_r;
  reg fs_d_r;
  reg ms_d_r;
  reg tx_bit_r;
  reg tx_bit_nxt;
  reg [7:0] tx_pos_nxt;
  reg [3:0] tx_fr_nxt;
  reg ami_pol_r;
  wire tx_dly;
  wire [4:0] tx_slot = slot_of(tx_pos_r);
  wire [2:0] tx_b = tx_pos_r[2:0];
  wire fs_rise = ti_fs & ~fs_d_r;
  wire ms_rise = ti_ms & ~ms_d_r;
  wire [7:0] idle_code = `E1F_IDLE_CODE;

  // Bit value after signaling and idle insertion, still NRZ.
  always @* begin
    tx_bit_nxt = ti_ser;
    if (tx_slot == `E1F_SLOT_SIGNAL && tx_fr_r == `E1F_FRAME_FIRST &&
        !ccs_mode) begin
      case (tx_b)
        3'h4: tx_bit_nxt = xsrc_int ? xbits_r[`E1F_XB_X1] : ti_xb;
        3'h5: tx_bit_nxt = xbits_r[`E1F_XB_ALARM];
        3'h6: tx_bit_nxt = xsrc_int ? xbits_r[`E1F_XB_X2] : ti_xb;
        3'h7: tx_bit_nxt = xsrc_int ? xbits_r[`E1F_XB_X3] : ti_xb;
        default: tx_bit_nxt = 1'b0;
      endcase
    end else if (tx_slot != `E1F_SLOT_FRAMING &&
                 tx_slot != `E1F_SLOT_SIGNAL && idle_r[tx_slot]) begin
      tx_bit_nxt = idle_code[~tx_b];
    end
  end

  // Next bit and frame position; a sync rise marks the last bit.
  always @* begin
    tx_pos_nxt = tx_pos_r + 8'h01;
    tx_fr_nxt = tx_fr_r;
    if (ms_rise || fs_rise) begin
      tx_pos_nxt = 8'h00;
    end
    if (ms_rise) begin
      tx_fr_nxt = `E1F_FRAME_FIRST;
    end else if (tx_pos_nxt == 8'h00) begin
      tx_fr_nxt = tx_fr_r + 4'h1;
    end
  end

  // Transmit state advances once per line-clock period.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pos_r <= 8'h00;
      tx_fr_r <= 4'h0;
      fs_d_r <= 1'b0;
      ms_d_r <= 1'b0;
      tx_bit_r <= 1'b0;
      tx_multiframe_align_out <= 1'b0;
      tx_align_frame_out <= 1'b0;
    end else if (tx_adv) begin
      fs_d_r <= ti_fs;
      ms_d_r <= ti_ms;
      tx_bit_r <= tx_bit_nxt;
      tx_pos_r <= tx_pos_nxt;
      tx_fr_r <= tx_fr_nxt;
      tx_multiframe_align_out <= (tx_fr_nxt == `E1F_FRAME_FIRST);
      tx_align_frame_out <= (tx_fr_nxt[0] == odd_align);
    end
  end

  // Pipeline that brings the total transmit latency to five periods.
  e1f_bit_delay #(
    .DEPTH(`E1F_TX_LAT - 1)
  ) u_tx_delay (
    .clk(clk),
    .rst_n(rst_n),
    .adv(tx_adv),
    .din(tx_bit_r),
    .dout(tx_dly)
  );

  // AMI line encoder: marks alternate between the two line outputs.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_pos <= 1'b0;
      line_out_neg <= 1'b0;
      ami_pol_r <= 1'b0;
    end else if (tx_adv) begin
      line_out_pos <= tx_dly & ~ami_pol_r;
      line_out_neg <= tx_dly & ami_pol_r;
      if (tx_dly) begin
        ami_pol_r <= ~ami_pol_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive decoding and delay
  // ----------------------------------------------------------------------
  reg [`E1F_RX_DEC_LEN-1:0] dec_r;
  reg last_pol_r;
  wire rx_mark = ri_pos | ri_neg;
  wire rx_viol = hdb3_en & ri_pos & (ri_pos == last_pol_r) |
                 hdb3_en & ri_neg & (ri_pos == last_pol_r);
  wire rx_mid;

  // HDB3 decode: a violation clears itself and the filler three bits back.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_r <= {`E1F_RX_DEC_LEN{1'b0}};
      last_pol_r <= 1'b0;
    end else if (rx_adv) begin
      dec_r <= {dec_r[2] & ~rx_viol, dec_r[1:0], rx_mark & ~rx_viol};
      if (rx_mark) begin
        last_pol_r <= ri_pos;
      end
    end
  end

  e1f_bit_delay #(
    .DEPTH(`E1F_RX_LAT - `E1F_RX_DEC_LEN)
  ) u_rx_delay (
    .clk(clk),
    .rst_n(rst_n),
    .adv(rx_adv),
    .din(dec_r[`E1F_RX_DEC_LEN-1]),
    .dout(rx_mid)
  );

  // ----------------------------------------------------------------------
  // Receive framing and signaling extraction
  // ----------------------------------------------------------------------
  reg [7:0] rx_pos_r;
  reg [7:0] hist_r;
  reg rx_align_r;
  reg crc_off_r;
  reg [7:0] sig_r;
  reg [7:0] rp;
  reg [3:0] rfr;
  reg ralign;
  reg rlock;
  reg rcrc_off;
  reg [3:0] nib;
  reg sd_nxt;
  wire [7:0] hist_nxt = {hist_r[6:0], rx_mid};
  wire fas_hit = (hist_nxt[6:0] == `E1F_FAS);
  wire [4:0] rs = slot_of(rp);
  wire [3:0] rfr_prev = rfr - 4'h1;
  wire [3:0] crc_fr = rfr - {3'h0, rcrc_off};

  // Position, frame and lock of the bit now leaving on rx_serial_out.
  always @* begin
    rp = rx_pos_r + 8'h01;
    rfr = rx_fr_r;
    ralign = rx_align_r;
    rlock = rx_lock_r;
    rcrc_off = crc_off_r;
    if (!rx_lock_r && fas_hit) begin
      rp = `E1F_POS_FAS_END;
      ralign = 1'b1;
      rlock = 1'b1;
    end else if (rp == 8'h00) begin
      rfr = rx_fr_r + 4'h1;
      ralign = ~rx_align_r;
    end else if (rx_lock_r && rp == `E1F_POS_FAS_END && rx_align_r &&
                 !fas_hit) begin
      rlock = 1'b0;
    end else if (rx_lock_r && rp == `E1F_POS_MFAS_END &&
                 hist_nxt[3:0] == 4'h0) begin
      rfr = `E1F_FRAME_FIRST;
      rcrc_off = ~rx_align_r;
    end
  end

  // Serial signaling: bits A..D in positions 5..8 of designated slots.
  always @* begin
    nib = 4'h0;
    sd_nxt = 1'b0;
    if (rs[4] == 1'b0 && rs[3:0] == rfr_prev && rs != 5'h00) begin
      nib = sig_r[7:4];
    end else if (rs[4] == 1'b1 && rs[3:0] == rfr && rs != 5'h10) begin
      nib = sig_r[3:0];
    end
    if ((rs != `E1F_SLOT_FRAMING) && (rs != `E1F_SLOT_SIGNAL) &&
        rp[2]) begin
      sd_nxt = nib[~rp[1:0]];
    end
  end

  // Receive state and outputs advance once per receive line period.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_pos_r <= 8'h00;
      rx_fr_r <= 4'h0;
      rx_lock_r <= 1'b0;
      rx_align_r <= 1'b0;
      crc_off_r <= 1'b0;
      hist_r <= 8'h00;
      sig_r <= 8'h00;
      rx_serial_out <= 1'b0;
      rx_signaling_out <= 1'b0;
      rx_frame_sync_out <= 1'b0;
      rx_multiframe_sync_out <= 1'b0;
      rx_crc_multiframe_sync_out <= 1'b0;
      rx_align_frame_out <= 1'b0;
    end else if (rx_adv) begin
      rx_pos_r <= rp;
      rx_fr_r <= rfr;
      rx_lock_r <= rlock;
      rx_align_r <= ralign;
      crc_off_r <= rcrc_off;
      hist_r <= hist_nxt;
      if (rp == `E1F_POS_SIG_END) begin
        sig_r <= hist_nxt;
      end
      rx_serial_out <= rx_mid;
      rx_signaling_out <= sd_nxt;
      rx_frame_sync_out <= (rp == `E1F_POS_LAST);
      rx_multiframe_sync_out <= (rp == `E1F_POS_LAST) &&
                                (rfr == `E1F_FRAME_LAST);
      rx_crc_multiframe_sync_out <= (rp == `E1F_POS_LAST) &&
                                    (crc_fr == `E1F_FRAME_LAST);
      rx_align_frame_out <= ralign;
    end
  end

endmodule // e1f_framer

`default_nettype wire

// [logic/e1f_regs.vh]
// Purpose: Constants of the E1 framer timing and signaling block.
// Assumes: Included by the framer top and the self-checking bench.
// Notes: Register offsets are byte addresses on the APB slave.
`ifndef E1F_REGS_VH
`define E1F_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define E1F_OFS_CTRL 8'h00
`define E1F_OFS_XBITS 8'h04
`define E1F_OFS_IDLE0 8'h08
`define E1F_OFS_IDLE1 8'h0c
`define E1F_OFS_IDLE2 8'h10
`define E1F_OFS_IDLE3 8'h14
`define E1F_OFS_STATUS 8'h18

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define E1F_CTRL_HDB3 0
`define E1F_CTRL_XSRC 2
`define E1F_CTRL_CCS 5
`define E1F_CTRL_PARITY 6
`define E1F_XB_X3 0
`define E1F_XB_X2 1
`define E1F_XB_ALARM 2
`define E1F_XB_X1 3
`define E1F_CTRL_RST 8'h00
`define E1F_XBITS_RST 8'h00
`define E1F_IDLE_RST 8'h00

// ----------------------------------------------------------------------
// Frame layout and timing
// ----------------------------------------------------------------------
`define E1F_IDLE_CODE 8'hd5
`define E1F_FAS 7'h1b
`define E1F_SLOT_FRAMING 5'h00
`define E1F_SLOT_SIGNAL 5'h10
`define E1F_POS_LAST 8'hff
`define E1F_POS_FAS_END 8'h07
`define E1F_POS_MFAS_END 8'h83
`define E1F_POS_SIG_END 8'h87
`define E1F_FRAME_FIRST 4'h0
`define E1F_FRAME_LAST 4'hf
`define E1F_TX_LAT 5
`define E1F_RX_LAT 6
`define E1F_RX_DEC_LEN 4

`endif

// [logic/e1f_sync2.v]
// Purpose: Two-flop synchroniser for a group of level inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: Only the second stage is seen by other logic.
`timescale 1ns/1ps
`default_nettype none

module e1f_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Data.
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule // e1f_sync2

`default_nettype wire

// [verif/e1f_framer_sva.sv]
// Purpose: Concurrent checks on the framer ports.
// Assumes: Bound to every e1f_framer instance; one clock domain.
// Notes: Receive sync checks hold before and after lock.
`timescale 1ns/1ps
`default_nettype none

module e1f_framer_sva (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Register port.
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Line and sync outputs.
  input wire line_out_pos,
  input wire line_out_neg,
  input wire tx_multiframe_align_out,
  input wire rx_frame_sync_out,
  input wire rx_multiframe_sync_out,
  input wire rx_crc_multiframe_sync_out
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup.");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long.");
  a_unmapped_err: assert property (pready |-> pslverr ==
    !(paddr[1:0] == 2'h0 && paddr <= 8'h18))
    else $error("pslverr wrong for address.");
  a_upper_zero: assert property (pready && !pwrite && paddr != 8'h18
    |-> prdata[31:8] == 24'h000000) else $error("Upper read bits set.");
  a_line_exclusive: assert property (!(line_out_pos && line_out_neg))
    else $error("Both line outputs high.");
  a_line_stands: assert property ($changed(line_out_pos)
    |=> $stable(line_out_pos) [*8]) else $error("Line output too short.");
  a_msync_in_fsync: assert property (rx_multiframe_sync_out
    |-> rx_frame_sync_out) else $error("Multiframe sync outside frame sync.");
  a_csync_in_fsync: assert property (rx_crc_multiframe_sync_out
    |-> rx_frame_sync_out) else $error("CRC sync outside frame sync.");
  a_msync_fall: assert property ($fell(rx_multiframe_sync_out)
    |-> $fell(rx_frame_sync_out)) else $error("Multiframe sync fell alone.");
  a_fsync_width: assert property ($rose(rx_frame_sync_out)
    |-> rx_frame_sync_out [*8] ##[1:40] !rx_frame_sync_out)
    else $error("Frame sync width wrong.");
  // Main scenarios reached.
  c_unmapped: cover property (pready && pslverr);
  c_mf_align: cover property ($rose(tx_multiframe_align_out));
  c_rx_sync: cover property ($rose(rx_frame_sync_out));
  c_neg_mark: cover property ($rose(line_out_neg));
endmodule // e1f_framer_sva

bind e1f_framer e1f_framer_sva i_e1f_framer_sva (.*);

`default_nettype wire

// [verif/e1f_framer_tb_top.sv]
// Purpose: Self-checking bench of the framer with a looped line.
// Assumes: The line model restarts with every reset.
// Notes: Each transmit scenario resets, configures, runs 160 or 540 line bits and checks all but the first 16.
`timescale 1ns/1ps
`default_nettype none
`include "e1f_regs.vh"

module e1f_framer_tb_top;
  logic clk, rst_n, psel, penable, pwrite;
  logic [7:0] paddr, ctrl_r, xb_r;
  logic [31:0] pwdata, idle_r;
  wire [31:0] prdata;
  wire pready, pslverr, tx_line_clock, tx_serial_in, extra_bit_in;
  wire tx_frame_sync_in, tx_multiframe_sync_in, line_out_pos, line_out_neg;
  wire tx_multiframe_align_out, tx_align_frame_out, rx_line_clock;
  wire line_in_pos, line_in_neg, rx_serial_out, rx_signaling_out;
  wire rx_frame_sync_out, rx_multiframe_sync_out;
  wire rx_crc_multiframe_sync_out, rx_align_frame_out;
  wire [7:0] pos_r;
  wire [3:0] frame_r;
  integer fails = 0;
  integer compares = 0;
  integer cycles = 0;

  e1f_framer i_e1f_framer (.*);
  e1f_line_model i_e1f_line_model (.*);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clock and a cycle limit that ends a hang.
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end

  task report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares = compares + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the answer is taken in the access cycle.
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, {24'h000000, d}, r, e);
  endtask

  // Line bit expected for a given input position and frame.
  function logic exp_bit(input logic [7:0] p, input logic [3:0] f);
    logic [7:0] s;
    s = ctrl_r[2] ? {4'h0, xb_r[3:0]} : {4'h0, ~p[1], xb_r[2], ~p[1], ~p[1]};
    if (p[7:3] == 5'h10 && f == 4'h0 && !ctrl_r[5]) return s[3'h7 - p[2:0]];
    s = 8'hd5;
    if (p[7:3] != 5'h00 && p[7:3] != 5'h10 && idle_r[p[7:3]])
      return s[3'h7 - p[2:0]];
    return p[0] ^ p[1] ^ p[4];
  endfunction

  task restart(input logic [7:0] c, input logic [7:0] x, input logic [31:0] i);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ctrl_r = c;
    xb_r = x;
    idle_r = i;
    wr(`E1F_OFS_CTRL, c);
    wr(`E1F_OFS_XBITS, x);
    wr(`E1F_OFS_IDLE0, i[7:0]);
    wr(`E1F_OFS_IDLE1, i[15:8]);
    wr(`E1F_OFS_IDLE2, i[23:16]);
    wr(`E1F_OFS_IDLE3, i[31:24]);
  endtask

  // Checks each line bit against the input five periods before.
  task run_bits(input integer n);
    integer k;
    logic [5:0] eh;
    logic [7:0] p;
    logic [3:0] f;
    eh = 6'h00;
    for (k = 0; k < n; k = k + 1) begin
      @(posedge tx_line_clock);
      p = pos_r;
      f = frame_r;
      eh = {eh[4:0], exp_bit(p, f)};
      repeat (20) @(posedge clk);
      if (k >= 16) begin
        chk(line_out_pos | line_out_neg, eh[5], "line bit");
        if (p == 8'h80) begin
          chk(tx_align_frame_out, f[0] == ctrl_r[6], "align");
          chk(tx_multiframe_align_out, f == 4'h0, "mf align");
        end
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    logic [31:0] r;
    logic e;
    logic [7:0] a;
    integer k;
    a = `E1F_OFS_IDLE0;
    for (k = 0; k < 4; k = k + 1) begin
      apb(a, 1'b0, 32'h00000000, r, e);
      chk(r, 32'h00000000, "idle reset");
      a = a + 8'h04;
    end
    apb(`E1F_OFS_IDLE1, 1'b1, 32'hffffff5a, r, e);
    apb(`E1F_OFS_IDLE1, 1'b0, 32'h00000000, r, e);
    chk(r, 32'h0000005a, "idle readback");
    apb(8'h1c, 1'b0, 32'h00000000, r, e);
    chk(e, 32'h00000001, "unmapped err");
    chk(r, 32'h00000000, "unmapped data");
    $display("test regs done");
  endtask

  task t_cas_int;
    restart(8'h04, 8'h0d, 32'h80030005);
    run_bits(540);
    $display("test cas internal done");
  endtask

  task t_cas_ext;
    restart(8'h40, 8'h00, 32'h00008100);
    run_bits(160);
    $display("test cas external done");
  endtask

  task t_ccs;
    restart(8'h21, 8'h0f, 32'h00010000);
    run_bits(160);
    $display("test ccs done");
  endtask

  // Receive data must appear six receive periods after the line.
  task t_rx;
    integer k;
    logic [6:0] h;
    h = 7'h00;
    for (k = 0; k < 40; k = k + 1) begin
      @(posedge rx_line_clock);
      h = {h[5:0], line_in_pos | line_in_neg};
      repeat (20) @(posedge clk);
      if (k >= 8) chk(rx_serial_out, h[6], "rx data");
    end
    $display("test rx done");
  endtask

  // Main sequence.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ctrl_r = 8'h00;
    xb_r = 8'h00;
    idle_r = 32'h00000000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_cas_int;
    t_cas_ext;
    t_ccs;
    t_rx;
    report_and_stop;
  end
endmodule // e1f_framer_tb_top

`default_nettype wire

// [verif/e1f_line_model.sv]
// Purpose: Line and backplane partner of the framer.
// Assumes: Shares the system reset with the framer.
// Notes: Restarts near the end of frame 15 so alignment comes soon.
`timescale 1ns/1ps
`default_nettype none

module e1f_line_model (
  // Reset.
  input wire rst_n,
  // Transmit side.
  output logic tx_line_clock,
  output wire tx_serial_in,
  output wire extra_bit_in,
  output wire tx_frame_sync_in,
  output wire tx_multiframe_sync_in,
  // Receive side, looped back from the line outputs.
  input wire line_out_pos,
  input wire line_out_neg,
  output wire rx_line_clock,
  output wire line_in_pos,
  output wire line_in_neg,
  // Position of the bit now offered.
  output logic [7:0] pos_r,
  output logic [3:0] frame_r
);
  // ----------------------------------------------------------------
  // Clock and position
  // ----------------------------------------------------------------
  // The line clock is offset so its edges never meet the system clock.
  initial begin
    tx_line_clock = 1'b0;
    #1.3;
    forever #80 tx_line_clock = ~tx_line_clock;
  end
  // Data changes on the falling edge, half a period from sampling.
  always @(negedge tx_line_clock or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= 8'hf9;
      frame_r <= 4'hf;
    end else begin
      pos_r <= pos_r + 8'h01;
      if (pos_r == 8'hff) frame_r <= frame_r + 4'h1;
    end
  end
  // Payload pattern, extra bits and syncs raised with the last bit.
  assign tx_serial_in = pos_r[0] ^ pos_r[1] ^ pos_r[4];
  assign extra_bit_in = ~pos_r[1];
  assign tx_frame_sync_in = (pos_r == 8'hff);
  assign tx_multiframe_sync_in = (pos_r == 8'hff) && (frame_r == 4'hf);
  // The receive clock runs at the same rate, half a period late.
  assign rx_line_clock = ~tx_line_clock;
  assign line_in_pos = line_out_pos;
  assign line_in_neg = line_out_neg;
endmodule // e1f_line_model

`default_nettype wire
